// >>> src/rip_regs.v
`timescale 1ns/1ps
`include "rip_consts.vh"
module rip_regs (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // selection result per timing path: valid flag and index (0 = input three)
  output reg         main_sel_valid,
  output reg  [1:0]  main_sel_idx,
  output reg         aux_sel_valid,
  output reg  [1:0]  aux_sel_idx
);
  // bank index: 0 reaches the main timing path copy, 1 the auxiliary timing path copy
  localparam BANK_MAIN = 1'b0;
  localparam BANK_AUX  = 1'b1;
  localparam N_BANK    = 2;

  // bank select and read path
  reg         path_bank_select_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;

  // address decode, at most one of these is high
  wire        hit_p34;
  wire        hit_p56;
  wire        hit_sel;

  // transfer qualifiers
  wire        setup_ph;
  wire        wr_en;
  wire        wr_p34;
  wire        wr_p56;
  wire        wr_sel;

  // per-bank views: byte or slice b belongs to bank b
  wire [15:0] bank_p34;
  wire [15:0] bank_p56;
  wire [1:0]  bank_ok;
  wire [3:0]  bank_idx;
  wire [7:0]  stat_byte;

  genvar      b;

  assign hit_p34  = (paddr == `RIP_OFF_PRIO_34);
  assign hit_p56  = (paddr == `RIP_OFF_PRIO_56);
  assign hit_sel  = (paddr == `RIP_OFF_SRC_SEL);

  // pready is held high, so the access phase is one cycle and a write lands at its edge
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign wr_p34   = wr_en & hit_p34;
  assign wr_p56   = wr_en & hit_p56;
  assign wr_sel   = wr_en & hit_sel;

  // status byte is built from the registered outputs, so a read agrees with the pins
  assign stat_byte[7]   = aux_sel_valid;
  assign stat_byte[6]   = 1'b0;
  assign stat_byte[5:4] = aux_sel_idx;
  assign stat_byte[3]   = main_sel_valid;
  assign stat_byte[2]   = 1'b0;
  assign stat_byte[1:0] = main_sel_idx;

  // a new bank select steers the next transfer, never the one that writes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_bank_select_r <= 1'b0;
    end else if (wr_sel) begin
      path_bank_select_r <= pwdata[`RIP_SEL_BANK_BIT];
    end
  end

  generate
    for (b = 0; b < N_BANK; b = b + 1) begin : g_bank
      localparam BANK_ID = (b == 1) ? BANK_AUX : BANK_MAIN;
      wire        bank_hit;
      wire [15:0] prio_all;
      reg  [7:0]  p34_r;
      reg  [7:0]  p56_r;

      // only the copy chosen by the bank select takes a write
      assign bank_hit = (path_bank_select_r == BANK_ID);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p34_r <= (BANK_ID == BANK_AUX) ? `RIP_RST_34_AUX : `RIP_RST_34_MAIN;
        end else if (wr_p34 && bank_hit) begin
          p34_r <= pwdata[7:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          p56_r <= (BANK_ID == BANK_AUX) ? `RIP_RST_56_AUX : `RIP_RST_56_MAIN;
        end else if (wr_p56 && bank_hit) begin
          p56_r <= pwdata[7:0];
        end
      end

      assign bank_p34[8*b +: 8] = p34_r;
      assign bank_p56[8*b +: 8] = p56_r;

      // each bank is ranked on its own, so both paths keep a choice whichever copy software reaches
      assign prio_all = {p56_r[`RIP_HI_NIB],
                         p56_r[`RIP_LO_NIB],
                         p34_r[`RIP_HI_NIB],
                         p34_r[`RIP_LO_NIB]};

      rip_pick u_pick (
        .prio     (prio_all),
        .any_ok   (bank_ok[b]),
        .best_idx (bank_idx[2*b +: 2])
      );
    end
  endgenerate

  // software sees only the copy that the bank select points at
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `RIP_OFF_PRIO_34: begin
        rd_nxt[7:0] = bank_p34[8*path_bank_select_r +: 8];
      end
      `RIP_OFF_PRIO_56: begin
        rd_nxt[7:0] = bank_p56[8*path_bank_select_r +: 8];
      end
      `RIP_OFF_SRC_SEL: begin
        rd_nxt[`RIP_SEL_BANK_BIT] = path_bank_select_r;
      end
      `RIP_OFF_SELECTED: begin
        rd_nxt[7:0] = stat_byte;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // anything outside the four words, unaligned offsets included, is refused
  always @* begin
    err_nxt = 1'b0;
    case (paddr)
      `RIP_OFF_PRIO_34,
      `RIP_OFF_PRIO_56,
      `RIP_OFF_SRC_SEL,
      `RIP_OFF_SELECTED: begin
        err_nxt = 1'b0;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // no wait states: every access phase completes on its first edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  // captured in setup so the answer stands still through the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && pwrite) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= rd_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= err_nxt;
    end
  end

  // selection outputs lag a priority write by one edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_sel_valid <= 1'b0;
    end else begin
      main_sel_valid <= bank_ok[BANK_MAIN];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_sel_idx <= 2'h0;
    end else begin
      main_sel_idx <= bank_idx[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_sel_valid <= 1'b0;
    end else begin
      aux_sel_valid <= bank_ok[BANK_AUX];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_sel_idx <= 2'h0;
    end else begin
      aux_sel_idx <= bank_idx[3:2];
    end
  end
endmodule // rip_regs

// >>> src/rip_consts.vh
`ifndef RIP_CONSTS_VH
`define RIP_CONSTS_VH
`define RIP_OFF_PRIO_34    12'h000
`define RIP_OFF_PRIO_56    12'h004
`define RIP_OFF_SRC_SEL    12'h008
`define RIP_OFF_SELECTED   12'h00C
`define RIP_SEL_BANK_BIT   4
`define RIP_RST_34_MAIN    8'h54
`define RIP_RST_34_AUX     8'h00
`define RIP_RST_56_MAIN    8'h76
`define RIP_RST_56_AUX     8'h76
`define RIP_LO_NIB         3:0
`define RIP_HI_NIB         7:4
`endif

// >>> src/rip_pick.v
`timescale 1ns/1ps
`include "rip_consts.vh"
// picks the highest-priority enabled input among four; index 0 = input three
module rip_pick (
  // priorities, packed input three in [3:0]
  input  wire [15:0] prio,
  // result
  output reg         any_ok,
  output reg  [1:0]  best_idx
);
  reg [3:0] best_val;
  integer   i;
  always @* begin
    any_ok   = 1'b0;
    best_idx = 2'h0;
    best_val = 4'hF;
    for (i = 0; i < 4; i = i + 1) begin
      // zero means excluded; strict compare keeps the lower input on ties
      if (prio[i*4 +: 4] != 4'h0 && (!any_ok || prio[i*4 +: 4] < best_val)) begin
        any_ok   = 1'b1;
        best_idx = i[1:0];
        best_val = prio[i*4 +: 4];
      end
    end
  end
endmodule // rip_pick

// >>> tb/rip_regs_chk.sv
`timescale 1ns/1ps
module rip_regs_chk (
  // apb
  input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  // selection
  input wire        main_sel_valid, aux_sel_valid,
  input wire [1:0]  main_sel_idx, aux_sel_idx
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  wire bad = paddr > 12'h00C || paddr[1:0] != 2'h0;
  wire wr  = psel && penable && pwrite;
  rdy_high_a: assert property (pready) else $error("pready low");
  err_flag_a: assert property (setup_s ##0 bad |=> pslverr && (pwrite || prdata == 32'h0)) else $error("not refused");
  ok_flag_a: assert property (setup_s ##0 !bad |=> !pslverr) else $error("mapped access flagged");
  rd_width_a: assert property (setup_s ##0 !pwrite |=> prdata[31:8] == 24'h0) else $error("high bits set");
  bank_read_a: assert property (setup_s ##0 !pwrite && paddr == 12'h008 |=> (prdata & 32'hEF) == 32'h0)
    else $error("select reads extra bits");
  stat_read_a: assert property (setup_s ##0 !pwrite && paddr == 12'h00C |=> prdata[7:0] ==
    {$past(aux_sel_valid), 1'b0, $past(aux_sel_idx), $past(main_sel_valid), 1'b0, $past(main_sel_idx)})
    else $error("status read wrong");
  sel_hold_a: assert property ($changed({main_sel_valid, main_sel_idx, aux_sel_valid, aux_sel_idx}) |->
    $past(wr, 2) || !$past(presetn) || !$past(presetn, 2)) else $error("selection moved without write");
endmodule // rip_regs_chk
bind rip_regs rip_regs_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .main_sel_valid(main_sel_valid), .aux_sel_valid(aux_sel_valid), .main_sel_idx(main_sel_idx),
  .aux_sel_idx(aux_sel_idx));

// >>> tb/rip_regs_tb.sv
`timescale 1ns/1ps
module rip_regs_tb;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, bk;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [7:0]  sh [0:3];
  wire [31:0] prdata;
  wire        pready, pslverr, mv, av;
  wire [1:0]  mi, ai;
  integer     fail_count = 0, checks = 0, i, j;
  always #12.5 pclk = ~pclk;
  rip_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_sel_valid(mv),
    .main_sel_idx(mi), .aux_sel_valid(av), .aux_sel_idx(ai));
  task close_out; begin
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  task chk(input [48:1] n, input [31:0] g, input [31:0] e); begin
    checks = checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s exp %h got %h", n, e, g);
    end
  end endtask
  // ends on an idle cycle so the next setup never re-drives psel in the same step
  task apb(input w, input [11:0] a, input [31:0] d); begin
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
    if (w && a == 12'h008) bk = d[4];
    if (w && a < 12'h008) sh[{bk, a[2]}] = d[7:0];
  end endtask
  // ties go to the lower input; zero excludes
  function [3:0] pick(input [15:0] p); integer k; reg [3:0] b; begin
    pick = 4'h0; b = 4'h0;
    for (k = 0; k < 4; k = k + 1)
      if (p[4*k+:4] != 4'h0 && (!pick[3] || p[4*k+:4] < b)) begin pick = {2'h2, k[1:0]}; b = p[4*k+:4]; end
  end endfunction
  task rall; reg [7:0] e, m; begin
    for (j = 0; j < 2; j = j + 1) begin apb(0, j[9:0] * 4, 0); chk("prio", rd, sh[{bk, j[0]}]); chk("perr", er, 0); end
    apb(0, 12'h008, 0); chk("srcsel", rd, {bk, 4'h0});
    apb(0, 12'h00C, 0);
    e = {pick({sh[3], sh[2]}), pick({sh[1], sh[0]})};
    m = {e[7] ? 4'hF : 4'hC, e[3] ? 4'hF : 4'hC};
    chk("status", rd & m, e);
    chk("selout", {av, 1'b0, ai, mv, 1'b0, mi} & m, e);
    apb(0, 12'h010, 0); chk("unmap", {er, rd[30:0]}, 32'h80000000);
  end endtask
  initial begin
    sh[0] = 8'h54; sh[1] = 8'h76; sh[2] = 8'h00; sh[3] = 8'h76; bk = 0;
    i = $urandom(32'h2AB3);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rall; apb(1, 12'h008, 32'h10); rall;
    apb(1, 12'h000, 0); apb(1, 12'h004, 0); rall;
    for (i = 0; i < 60; i = i + 1) begin apb(1, ($urandom % 4) * 4, $urandom); rall; end
    apb(1, 12'h000, 32'h33); apb(1, 12'h004, 32'h33); rall;
    presetn <= 0; sh[0] = 8'h54; sh[1] = 8'h76; sh[2] = 8'h00; sh[3] = 8'h76; bk = 0;
    @(posedge pclk); presetn <= 1; @(posedge pclk); rall;
    close_out;
  end
  initial begin #200000; fail_count = fail_count + 1; close_out; end
endmodule // rip_regs_tb
